// ===== hw/mixer_defs.svh
`ifndef MIXER_DEFS_SVH
`define MIXER_DEFS_SVH

// =========================================
// Register bus geometry
`define MIX_ADDR_W 2
`define MIX_DATA_W 8

// =========================================
// Register offsets
`define MIX_CTRL_ADDR 2'h0
`define MIX_MSRC_ADDR 2'h1
`define MIX_HCAR_ADDR 2'h2
`define MIX_LCAR_ADDR 2'h3

// =========================================
// Mixer control register fields
`define MIX_CTRL_EN 7
`define MIX_CTRL_OE 6
`define MIX_CTRL_SLEW 5
`define MIX_CTRL_OINV 4
`define MIX_CTRL_OUT 3
`define MIX_CTRL_SWBIT 0
`define MIX_CTRL_SLEW_RST 1'h1

// =========================================
// Source and carrier control register fields
`define MIX_SEL_HI 3
`define MIX_SEL_LO 0
`define MIX_CAR_SYNC 5
`define MIX_CAR_INV 6

// =========================================
// Modulator source codes
`define MIX_MOD_PWM0 4'h0
`define MIX_MOD_SER0 4'h4
`define MIX_MOD_CMP0 4'h6
`define MIX_MOD_TX 4'h8
`define MIX_MOD_PIN 4'h9
`define MIX_MOD_SW 4'hA

// =========================================
// Carrier source codes
`define MIX_CAR_PWM0 4'h0
`define MIX_CAR_REF 4'h4
`define MIX_CAR_PIN_A 4'h5
`define MIX_CAR_PIN_B 4'h6
`define MIX_CAR_GND 4'h7

`endif

// ===== hw/mixer_pkg.sv
package mixer_pkg;

    // =========================================
    // Which carrier currently feeds the mixer.
    typedef enum logic {
        CARRIER_LOW,
        CARRIER_HIGH
    } carrier_t;

    // =========================================
    // Complete state of the mixer.
    typedef struct packed {
        logic enable;
        logic out_en;
        logic slew;
        logic out_inv;
        logic sw_bit;
        logic [3:0] mod_sel;
        logic [3:0] hi_sel;
        logic hi_sync;
        logic hi_inv;
        logic [3:0] lo_sel;
        logic lo_sync;
        logic lo_inv;
        logic [2:0] pin_meta;
        logic [2:0] pin_sync;
        carrier_t active;
        logic mixed;
        logic pin;
        logic [7:0] rdata;
    } mixer_state_t;

endpackage

// ===== hw/signal_mixer.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mixer_defs.svh"

// Functional notes
// - Output is selected carrier mixed with modulator.
// - Modulator high uses high carrier, low uses low.
// - Enable bit activates the mixer.
// - Disabled forces both carriers to ground.
// - Disabled takes modulator from software bit.
// - Disable keeps stored source selections intact.
// - Output enable off blocks pin, mixing continues.
// - Output enable off drives pin low.
// - Four-bit field selects modulator source.
// - Modulator sources: pwm, serial, comparator, tx, pin, bit.
// - Four-bit field selects high carrier.
// - Four-bit field selects low carrier.
// - Carrier sources: pwm, refclock, two pins, ground.
// - Synced carrier finishes its pulse before switching.
// - High and low sync enables are independent.
// - High sync bit delays leaving high carrier.
// - Low sync bit delays leaving low carrier.
// - Each carrier has its own invert bit.
// - Output invert bit inverts pin signal.
// - Reset disables mixer, registers take defaults.

module signal_mixer
    import mixer_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [`MIX_ADDR_W-1:0] addr_i,
    input wire logic [`MIX_DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`MIX_DATA_W-1:0] rdata_o,
    // On-chip peripheral sources.
    input wire logic [3:0] capture_compare_pwm_output_i,
    input wire logic [1:0] serial_data_output_i,
    input wire logic [1:0] comparator_output_i,
    input wire logic async_transmitter_i,
    input wire logic reference_clock_i,
    // External source pins.
    input wire logic external_modulator_input_i,
    input wire logic external_carrier_input_a_i,
    input wire logic external_carrier_input_b_i,
    // Output pin and its slew-limit control.
    output logic modulated_output_pin_o,
    output logic slew_limit_o
);

    // =========================================
    // Source selection functions
    // Unused codes give a constant low level.
    function automatic logic pick_carrier(input logic [3:0] sel, input logic [3:0] ccp,
                                          input logic refclk, input logic pa, input logic pb);
        logic v;
        v = 1'b0;
        case (sel)
            `MIX_CAR_PWM0, 4'h1, 4'h2, 4'h3: v = ccp[sel[1:0]];
            `MIX_CAR_REF: v = refclk;
            `MIX_CAR_PIN_A: v = pa;
            `MIX_CAR_PIN_B: v = pb;
            `MIX_CAR_GND: v = 1'b0;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic pick_modulator(input logic [3:0] sel, input logic [3:0] ccp,
                                            input logic [1:0] sdo, input logic [1:0] cmp,
                                            input logic tx, input logic pin,
                                            input logic swb);
        logic v;
        v = 1'b0;
        case (sel)
            `MIX_MOD_PWM0, 4'h1, 4'h2, 4'h3: v = ccp[sel[1:0]];
            `MIX_MOD_SER0, 4'h5: v = sdo[sel[0]];
            `MIX_MOD_CMP0, 4'h7: v = cmp[sel[0]];
            `MIX_MOD_TX: v = tx;
            `MIX_MOD_PIN: v = pin;
            `MIX_MOD_SW: v = swb;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // =========================================
    // State
    mixer_state_t state_reg;
    mixer_state_t state_next;
    logic mod_src;
    logic car_hi;
    logic car_lo;

    // Source muxes; a disabled mixer sees ground carriers and the software bit.
    always_comb begin
        mod_src = state_reg.sw_bit;
        car_hi = 1'b0;
        car_lo = 1'b0;
        if (state_reg.enable) begin
            mod_src = pick_modulator(state_reg.mod_sel, capture_compare_pwm_output_i,
                                     serial_data_output_i, comparator_output_i,
                                     async_transmitter_i, state_reg.pin_sync[0],
                                     state_reg.sw_bit);
            car_hi = pick_carrier(state_reg.hi_sel, capture_compare_pwm_output_i,
                                  reference_clock_i, state_reg.pin_sync[1],
                                  state_reg.pin_sync[2]) ^ state_reg.hi_inv;
            car_lo = pick_carrier(state_reg.lo_sel, capture_compare_pwm_output_i,
                                  reference_clock_i, state_reg.pin_sync[1],
                                  state_reg.pin_sync[2]) ^ state_reg.lo_inv;
        end
    end

    // =========================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        // External pins go through two flops before any use.
        state_next.pin_meta = {external_carrier_input_b_i, external_carrier_input_a_i,
                               external_modulator_input_i};
        state_next.pin_sync = state_reg.pin_meta;

        // Carrier switching follows the modulator unless the carrier being left is
        // synchronised and still mid-pulse, in which case it is held until low.
        state_next.active = mod_src ? CARRIER_HIGH : CARRIER_LOW;
        case (state_reg.active)
            CARRIER_HIGH: begin
                if (!mod_src && state_reg.hi_sync && car_hi) begin
                    state_next.active = CARRIER_HIGH;
                end
            end
            CARRIER_LOW: begin
                if (mod_src && state_reg.lo_sync && car_lo) begin
                    state_next.active = CARRIER_LOW;
                end
            end
            default: state_next.active = CARRIER_LOW;
        endcase

        // Mixing keeps running even while the pin is blocked.
        state_next.mixed = (state_next.active == CARRIER_HIGH) ? car_hi : car_lo;
        state_next.pin = state_reg.out_en
                         & (state_next.mixed ^ state_reg.out_inv);

        // Register writes; selections survive any change of the enable bit.
        if (we_i) begin
            case (addr_i)
                `MIX_CTRL_ADDR: begin
                    state_next.enable = wdata_i[`MIX_CTRL_EN];
                    state_next.out_en = wdata_i[`MIX_CTRL_OE];
                    state_next.slew = wdata_i[`MIX_CTRL_SLEW];
                    state_next.out_inv = wdata_i[`MIX_CTRL_OINV];
                    state_next.sw_bit = wdata_i[`MIX_CTRL_SWBIT];
                end
                `MIX_MSRC_ADDR: state_next.mod_sel = wdata_i[`MIX_SEL_HI:`MIX_SEL_LO];
                `MIX_HCAR_ADDR: begin
                    state_next.hi_sel = wdata_i[`MIX_SEL_HI:`MIX_SEL_LO];
                    state_next.hi_sync = wdata_i[`MIX_CAR_SYNC];
                    state_next.hi_inv = wdata_i[`MIX_CAR_INV];
                end
                `MIX_LCAR_ADDR: begin
                    state_next.lo_sel = wdata_i[`MIX_SEL_HI:`MIX_SEL_LO];
                    state_next.lo_sync = wdata_i[`MIX_CAR_SYNC];
                    state_next.lo_inv = wdata_i[`MIX_CAR_INV];
                end
                default: state_next.enable = state_reg.enable;
            endcase
        end

        // Read data stands only in the cycle after the read strobe.
        state_next.rdata = 8'h00;
        if (re_i) begin
            case (addr_i)
                `MIX_CTRL_ADDR: begin
                    state_next.rdata[`MIX_CTRL_EN] = state_reg.enable;
                    state_next.rdata[`MIX_CTRL_OE] = state_reg.out_en;
                    state_next.rdata[`MIX_CTRL_SLEW] = state_reg.slew;
                    state_next.rdata[`MIX_CTRL_OINV] = state_reg.out_inv;
                    state_next.rdata[`MIX_CTRL_OUT] = state_reg.mixed;
                    state_next.rdata[`MIX_CTRL_SWBIT] = state_reg.sw_bit;
                end
                `MIX_MSRC_ADDR: state_next.rdata[`MIX_SEL_HI:`MIX_SEL_LO] = state_reg.mod_sel;
                `MIX_HCAR_ADDR: begin
                    state_next.rdata[`MIX_SEL_HI:`MIX_SEL_LO] = state_reg.hi_sel;
                    state_next.rdata[`MIX_CAR_SYNC] = state_reg.hi_sync;
                    state_next.rdata[`MIX_CAR_INV] = state_reg.hi_inv;
                end
                `MIX_LCAR_ADDR: begin
                    state_next.rdata[`MIX_SEL_HI:`MIX_SEL_LO] = state_reg.lo_sel;
                    state_next.rdata[`MIX_CAR_SYNC] = state_reg.lo_sync;
                    state_next.rdata[`MIX_CAR_INV] = state_reg.lo_inv;
                end
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // Reset clears everything except the slew limiter, which defaults on.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.slew <= `MIX_CTRL_SLEW_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================
    // Outputs
    assign rdata_o = state_reg.rdata;
    assign modulated_output_pin_o = state_reg.pin;
    assign slew_limit_o = state_reg.slew;

    // =========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_hold_high;
        state_reg.active == CARRIER_HIGH && !mod_src && state_reg.hi_sync && car_hi;
    endsequence

    sequence s_leave_high;
        state_reg.active == CARRIER_HIGH && !mod_src && !car_hi;
    endsequence

    sequence s_hold_low;
        state_reg.active == CARRIER_LOW && mod_src && state_reg.lo_sync && car_lo;
    endsequence

    sequence s_leave_low;
        state_reg.active == CARRIER_LOW && mod_src && !car_lo;
    endsequence

    property p_sync_hold;
        s_hold_high |=> state_reg.active == CARRIER_HIGH;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("high carrier left mid-pulse");

    property p_sync_release;
        s_leave_high |=> state_reg.active == CARRIER_LOW;
    endproperty
    a_sync_release: assert property (p_sync_release) else $error("carrier switch lost");

    property p_sync_hold_low;
        s_hold_low |=> state_reg.active == CARRIER_LOW;
    endproperty
    a_sync_hold_low: assert property (p_sync_hold_low) else $error("low carrier cut");

    property p_sync_release_low;
        s_leave_low |=> state_reg.active == CARRIER_HIGH;
    endproperty
    a_sync_release_low: assert property (p_sync_release_low) else $error("switch lost");

    property p_follow_mod;
        (state_reg.enable && !state_reg.hi_sync && !state_reg.lo_sync)
            |=> state_reg.mixed == ($past(mod_src) ? $past(car_hi) : $past(car_lo));
    endproperty
    a_follow_mod: assert property (p_follow_mod) else $error("wrong carrier mixed");

    property p_mix_high;
        mod_src && !(state_reg.active == CARRIER_LOW && state_reg.lo_sync && car_lo)
            |=> state_reg.mixed == $past(car_hi);
    endproperty
    a_mix_high: assert property (p_mix_high) else $error("high carrier not mixed");

    property p_mix_low;
        !mod_src && !(state_reg.active == CARRIER_HIGH && state_reg.hi_sync && car_hi)
            |=> state_reg.mixed == $past(car_lo);
    endproperty
    a_mix_low: assert property (p_mix_low) else $error("low carrier not mixed");

    property p_ground;
        !state_reg.enable |-> !car_hi && !car_lo;
    endproperty
    a_ground: assert property (p_ground) else $error("carrier not grounded");

    property p_quiet;
        !state_reg.enable |=> !state_reg.mixed;
    endproperty
    a_quiet: assert property (p_quiet) else $error("disabled mixer not quiet");

    property p_hi_inv;
        (state_reg.enable && state_reg.hi_sel == `MIX_CAR_GND) |-> car_hi == state_reg.hi_inv;
    endproperty
    a_hi_inv: assert property (p_hi_inv) else $error("high carrier polarity wrong");

    property p_lo_inv;
        (state_reg.enable && state_reg.lo_sel == `MIX_CAR_GND) |-> car_lo == state_reg.lo_inv;
    endproperty
    a_lo_inv: assert property (p_lo_inv) else $error("low carrier polarity wrong");

    property p_sw_bit;
        !state_reg.enable |-> mod_src == state_reg.sw_bit;
    endproperty
    a_sw_bit: assert property (p_sw_bit) else $error("modulator not from software bit");

    property p_pin_low;
        !state_reg.out_en |=> !modulated_output_pin_o;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("blocked pin not low");

    property p_pin_inv;
        state_reg.out_en
            |=> modulated_output_pin_o == (state_reg.mixed ^ $past(state_reg.out_inv));
    endproperty
    a_pin_inv: assert property (p_pin_inv) else $error("pin polarity wrong");

    property p_keep_sel;
        (we_i && addr_i == `MIX_CTRL_ADDR) |=> state_reg.mod_sel == $past(state_reg.mod_sel);
    endproperty
    a_keep_sel: assert property (p_keep_sel) else $error("selection lost on enable");

    property p_enable;
        (we_i && addr_i == `MIX_CTRL_ADDR) |=> state_reg.enable == $past(wdata_i[`MIX_CTRL_EN]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit not taken");

    property p_unused;
        (state_reg.enable && state_reg.mod_sel > `MIX_MOD_SW) |-> !mod_src;
    endproperty
    a_unused: assert property (p_unused) else $error("unused code not low");

    property p_mod_pin;
        (state_reg.enable && state_reg.mod_sel == `MIX_MOD_PIN)
            |-> mod_src == state_reg.pin_sync[0];
    endproperty
    a_mod_pin: assert property (p_mod_pin) else $error("pin source wrong");

    property p_car_ref;
        (state_reg.enable && state_reg.lo_sel == `MIX_CAR_REF)
            |-> car_lo == (reference_clock_i ^ state_reg.lo_inv);
    endproperty
    a_car_ref: assert property (p_car_ref) else $error("reference carrier wrong");

    property p_lo_unused;
        (state_reg.enable && state_reg.lo_sel > `MIX_CAR_GND) |-> car_lo == state_reg.lo_inv;
    endproperty
    a_lo_unused: assert property (p_lo_unused) else $error("unused carrier not low");

    property p_pin_sync;
        !rst_i ##2 1'b1 |-> state_reg.pin_sync[1] == $past(external_carrier_input_a_i, 2);
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin synchroniser depth wrong");

endmodule

// ===== verification/mixer_sources.sv
`timescale 1ns/1ps

// =========================================
// Peripheral and pin sources facing the mixer
module mixer_sources (
    // Clock and source pattern.
    input wire logic clk_i,
    input wire logic [12:0] pat_i,
    // Source levels.
    output logic [3:0] pwm_o,
    output logic [1:0] sdo_o,
    output logic [1:0] cmp_o,
    output logic tx_o,
    output logic ref_o,
    output logic mod_pin_o,
    output logic car_a_o,
    output logic car_b_o
);
    // Sources move just after an edge, as the on-chip peripherals do.
    always_ff @(posedge clk_i) begin
        {car_b_o, car_a_o, mod_pin_o, ref_o, tx_o, cmp_o, sdo_o, pwm_o} <= pat_i;
    end
endmodule

// ===== verification/tb_signal_mixer.sv
`timescale 1ns/1ps
`include "mixer_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

// =========================================
// Testbench
module tb_signal_mixer;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, d, c, m, h, l;
    logic [12:0] pat = 13'h0000;
    logic [3:0] pwm;
    logic [1:0] sdo, cmp;
    logic tx, rf, mp, ca, cb, pin_o, slew_o;
    int failures = 0, comparisons = 0;
    // Clock of 100 MHz.
    always #5 clk_i = ~clk_i;
    mixer_sources src (.clk_i(clk_i), .pat_i(pat), .pwm_o(pwm), .sdo_o(sdo), .cmp_o(cmp),
        .tx_o(tx), .ref_o(rf), .mod_pin_o(mp), .car_a_o(ca), .car_b_o(cb));
    signal_mixer DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .capture_compare_pwm_output_i(pwm),
        .serial_data_output_i(sdo), .comparator_output_i(cmp), .async_transmitter_i(tx),
        .reference_clock_i(rf), .external_modulator_input_i(mp),
        .external_carrier_input_a_i(ca), .external_carrier_input_b_i(cb),
        .modulated_output_pin_o(pin_o), .slew_limit_o(slew_o));

    // Register bus cycles, changed right after the rising edge.
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Source picked by a modulator or carrier select code.
    function automatic logic pick(input logic [3:0] s, input logic [12:0] p, input logic car,
                                  input logic sw);
        if (car) return (s < 4) ? p[s[1:0]] : (s == 4) ? p[9] : (s == 5) ? p[11] :
            (s == 6) ? p[12] : 1'b0;
        return (s < 8) ? p[s[2:0]] : (s == 8) ? p[8] : (s == 9) ? p[10] : (s == 10) ? sw : 1'b0;
    endfunction
    // Expected mixed value before the output gate, sync off.
    function automatic logic mix(input logic [7:0] cr, ms, hc, lc, input logic [12:0] p);
        logic md, hi, lo;
        md = cr[7] ? pick(ms[3:0], p, 1'b0, cr[0]) : cr[0];
        hi = cr[7] ? pick(hc[3:0], p, 1'b1, 1'b0) ^ hc[6] : 1'b0;
        lo = cr[7] ? pick(lc[3:0], p, 1'b1, 1'b0) ^ lc[6] : 1'b0;
        return md ? hi : lo;
    endfunction
    task automatic chk_pin();
        wait_cyc(5);
        `CHK("pin", c[6] & (mix(c, m, h, l, pat) ^ c[4]), pin_o)
        `CHK("slew", c[5], slew_o)
        rd(2'h0, d);
        `CHK("mixed", mix(c, m, h, l, pat), d[3])
    endtask
    task automatic reset_check();
        @(posedge clk_i);
        rst_i <= 1'b1;
        wait_cyc(11);
        `CHK("pin_rst", 1'b0, pin_o)
        `CHK("slew_rst", 1'b1, slew_o)
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(i[1:0], d);
            `CHK("reg_rst", (i == 0) ? 8'h20 : 8'h00, d)
        end
    endtask
    // One synchronised or plain carrier change, then the held pulse ending.
    task automatic sync_case(input logic [7:0] hc, lc, input logic s0, hold);
        pat <= 13'h0001;
        wr(2'h1, 8'h0A);
        wr(2'h2, hc);
        wr(2'h3, lc);
        wr(2'h0, {7'h60, s0});
        wait_cyc(4);
        `CHK("sync_start", 1'b1, pin_o)
        wr(2'h0, {7'h60, ~s0});
        wait_cyc(4);
        `CHK("sync_hold", hold, pin_o)
        pat <= 13'h0000;
        wait_cyc(4);
        pat <= 13'h0001;
        wait_cyc(4);
        `CHK("sync_done", 1'b0, pin_o)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog cuts a hang short, at about two and a half times the expected run.
    initial begin
        #200_000;
        failures++;
        finish_test();
    end
    // Main sequence.
    initial begin
        void'($urandom(35));
        reset_check();
        for (int i = 0; i < 200; i++) begin
            c = 8'($urandom) & 8'hF1;
            m = 8'($urandom);
            h = 8'($urandom) & 8'hDF;
            l = 8'($urandom) & 8'hDF;
            pat <= 13'($urandom);
            wr(2'h1, m);
            wr(2'h2, h);
            wr(2'h3, l);
            wr(2'h0, c);
            chk_pin();
            rd(2'h1, d);
            `CHK("msrc", m & 8'h0F, d)
            rd(2'h2, d);
            `CHK("hcar", h & 8'h6F, d)
            rd(2'h3, d);
            `CHK("lcar", l & 8'h6F, d)
            c[7] = ~c[7];
            wr(2'h0, c);
            chk_pin();
            c[7] = ~c[7];
            wr(2'h0, c);
            chk_pin();
        end
        sync_case(8'h20, 8'h07, 1'b1, 1'b1);
        sync_case(8'h00, 8'h07, 1'b1, 1'b0);
        sync_case(8'h07, 8'h20, 1'b0, 1'b1);
        sync_case(8'h07, 8'h00, 1'b0, 1'b0);
        reset_check();
        finish_test();
    end
endmodule
